//--- src/pwt_channel.sv
// One PWM timer channel: counter, four compares, three pulse pins
`timescale 1ns/10ps
module pwt_channel (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic        stop_sel,
  input  wire logic        ld_cnt,
  input  wire logic [15:0] ld_val,
  input  wire logic [15:0] gr_a,
  input  wire logic [15:0] gr_b,
  input  wire logic [15:0] gr_c,
  input  wire logic [15:0] gr_d,
  input  wire logic [2:0]  pin_en,
  input  wire logic [2:0]  act_hi,
  input  wire logic [2:0]  init_lvl,
  input  wire logic        cutoff,
  output logic      [15:0] cnt,
  output logic      [3:0]  match,
  output logic             ovf,
  output logic             stop_req,
  output logic      [2:0]  pin_o,
  output logic      [2:0]  pin_oe
);
  typedef struct packed {
    logic [15:0] cnt;
    logic [2:0]  lvl;
    logic        was_run;
    logic [3:0]  match;
    logic        ovf;
    logic        stop_req;
    logic [2:0]  pin_o;
    logic [2:0]  pin_oe;
  } pwt_ch_state_t;

  pwt_ch_state_t q;
  pwt_ch_state_t d;
  logic [3:0][15:0] gr;
  logic             at_a;
  logic             step;

  assign gr   = {gr_d, gr_c, gr_b, gr_a};
  assign at_a = (q.cnt == gr_a);
  // Stop request blocks a second step at the period match before start clears
  assign step = run && q.was_run && tick && !ld_cnt && !q.stop_req;

  // ****************************************
  // Counting and pin levels
  // ****************************************
  always_comb begin
    d          = q;
    d.match    = 4'h0;
    d.ovf      = 1'b0;
    d.stop_req = 1'b0;
    d.was_run  = run;
    if (run && !q.was_run) begin
      d.lvl = init_lvl;
    end
    if (ld_cnt) begin
      d.cnt = ld_val;
    end else if (step) begin
      for (int h = 0; h < 4; h++) begin
        if (q.cnt == gr[h]) begin
          d.match[h] = 1'b1;
        end
      end
      if (at_a) begin
        d.cnt = pwt_pkg::RST_CNT;
        d.lvl = ~act_hi;
        if (!stop_sel) begin
          d.cnt      = q.cnt;
          d.stop_req = 1'b1;
        end
      end else begin
        d.cnt = q.cnt + 16'h0001;
        d.ovf = &q.cnt;
        for (int j = 0; j < 3; j++) begin
          if (q.cnt == gr[j+1]) begin
            d.lvl[j] = act_hi[j];
          end
        end
      end
    end
    // Cut off pins float so the external pull sets the safe level
    d.pin_oe = pin_en & {3{!cutoff}};
    d.pin_o  = cutoff ? 3'h0 : d.lvl;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cnt      = q.cnt;
  assign match    = q.match;
  assign ovf      = q.ovf;
  assign stop_req = q.stop_req;
  assign pin_o    = q.pin_o;
  assign pin_oe   = q.pin_oe;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_a_match;
    step && at_a;
  endsequence

  chk_load_count: assert property (ld_cnt |=> cnt == $past(ld_val))
    else $error("counter load lost");
  chk_match_flag: assert property (step && q.cnt == gr_c |=> match[2])
    else $error("compare C match not flagged");
  chk_period_wrap: assert property (s_a_match and stop_sel |=> cnt == 16'h0000)
    else $error("counter did not clear after period match");
  chk_stop_hold: assert property (s_a_match and !stop_sel |=> stop_req && $stable(cnt))
    else $error("stop at period match failed");
  chk_duty_edge: assert property (
    step && !at_a && q.cnt == gr_b && !cutoff |=> pin_o[0] == $past(act_hi[0]))
    else $error("pin did not turn active at duty match");
  chk_init_level: assert property (
    run && !q.was_run && !ld_cnt && !cutoff |=> pin_o == $past(init_lvl))
    else $error("initial level not driven");
  chk_cutoff_pins: assert property (cutoff |=> pin_oe == 3'h0)
    else $error("pins driven during cutoff");
endmodule

//--- src/pwt_pkg.sv
// Constants and types shared by the PWM timer block
package pwt_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam int DW   = 16;
  localparam int NCH  = 2;
  localparam int NPIN = 3;
  localparam logic [4:0] ADDR_START  = 5'h00;
  localparam logic [4:0] ADDR_CFG    = 5'h01;
  localparam logic [4:0] ADDR_EVMASK = 5'h02;
  localparam logic [4:0] ADDR_STATUS = 5'h03;
  localparam logic [1:0] CH0_REGION  = 2'h1;
  localparam logic [1:0] CH1_REGION  = 2'h2;
  localparam logic [2:0] OFF_CNT     = 3'h0;
  localparam logic [2:0] OFF_GR_A    = 3'h1;
  localparam logic [2:0] OFF_GR_D    = 3'h4;
  localparam logic [2:0] OFF_OUTCFG  = 3'h5;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int START_RUN_LSB  = 0;
  localparam int START_SEL_LSB  = 2;
  localparam int CFG_SRC_LSB    = 0;
  localparam int CFG_EDGE_LSB   = 3;
  localparam int CFG_CUT_EN_BIT = 5;
  localparam int CFG_EXTCLK_BIT = 6;
  localparam int OUT_EN_LSB     = 0;
  localparam int OUT_ACT_LSB    = 3;
  localparam int OUT_INIT_LSB   = 6;
  localparam int STAT_RUN_LSB   = 0;
  localparam int STAT_CUT_BIT   = 2;
  localparam int STAT_HALF_BIT  = 3;
  localparam int STAT_HS_OK_BIT = 4;
  // ****************************************
  // Reset values and encodings
  // ****************************************
  localparam logic [15:0] RST_CNT    = 16'h0000;
  localparam logic [15:0] RST_GR     = 16'hFFFF;
  localparam logic [8:0]  RST_OUTCFG = 9'h038;
  localparam logic [7:0]  RST_EVMASK = 8'h00;
  localparam logic [4:0]  RST_PRESC  = 5'h00;
  localparam logic [1:0]  EDGE_RISE  = 2'h0;
  localparam logic [1:0]  EDGE_FALL  = 2'h1;
  localparam logic [1:0]  OSC_LE32   = 2'h0;
  localparam logic [1:0]  OSC_48     = 2'h1;
  localparam logic [1:0]  OSC_64     = 2'h2;
  typedef enum logic [2:0] {
    SRC_DIV1  = 3'b000,
    SRC_DIV2  = 3'b001,
    SRC_DIV4  = 3'b010,
    SRC_DIV8  = 3'b011,
    SRC_DIV32 = 3'b100,
    SRC_HSOSC = 3'b101,
    SRC_EXT   = 3'b110
  } pwt_src_t;
endpackage

//--- src/pwt_top.sv
// Two-channel PWM timer with register port, count source and pin logic
`timescale 1ns/10ps
// Function
// - Flag request on counter match with any of four compares, and on overflow.
// - Counter reads return the live count without disturbing it.
// - Software write to the counter loads that value.
// - One to three PWM pins per channel, each enabled on its own.
// - Active level high or low chosen per pin.
// - Level driven before counting chosen per pin.
// - Enabled cutoff input on the shared interrupt pin forces pins to cutoff.
// - Compare-match events reach the event link to start conversions.
// - B, C, D pins each chosen as port pin or pulse output.
// - Channel 0 A pin is port pin or external clock, edge selectable.
// - Oscillator count source only usable when frequency select bit is 1.
// - Internal clock is half oscillator at 64 or 48 MHz, else equal.
// - Counter works with count source up to 64 MHz.
// - Period m+1 counts; pin active m-n counts, inactive n+1 counts.
// - Writing 1 to a start bit begins counting on that channel.
// - Stop select 1: clearing start holds pins; 0: stops at period match.
module pwt_top (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [4:0]  addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [15:0] rd_data,
  input  wire logic        ch0_a_pin,
  input  wire logic        ext_irq0_pin,
  input  wire logic        osc_freq_select_bit,
  input  wire logic [1:0]  osc_freq_code,
  input  wire logic        timer_periph_enable,
  output logic      [5:0]  pwm_o,
  output logic      [5:0]  pwm_oe,
  output logic      [1:0]  irq_req,
  output logic             adc_trig,
  output logic             internal_hs_half
);
  typedef struct packed {
    logic [2:0]            ext_s;
    logic [1:0]            cut_s;
    logic [1:0]            pen_s;
    logic [5:0]            opt_s;
    logic [4:0]            presc;
    logic [1:0]            start;
    logic [1:0]            stop_sel;
    logic [2:0]            src;
    logic [1:0]            edge_sel;
    logic                  cut_en;
    logic                  extclk;
    logic [7:0]            evmask;
    logic [1:0][3:0][15:0] gr;
    logic [1:0][8:0]       outcfg;
    logic [15:0]           rdata;
    logic                  tick;
    logic [1:0]            irq;
    logic                  adc;
    logic                  cutoff;
    logic                  ihs_half;
  } pwt_top_state_t;

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  pwt_top_state_t q;
  pwt_top_state_t d;

  logic [15:0] ch_cnt   [2];
  logic [3:0]  ch_match [2];
  logic        ch_ovf   [2];
  logic        ch_stop  [2];
  logic [2:0]  ch_pin_o [2];
  logic [2:0]  ch_pin_oe[2];
  logic [1:0]  ld_cnt;
  logic        ch_hit;
  logic        ch_idx;
  logic [2:0]  off;
  logic [1:0]  gr_idx;
  logic        ext_rise;
  logic        ext_fall;
  logic        ext_edge;
  logic        hs_ok;
  logic        src_tick;

  assign ch_hit = (addr[4:3] == pwt_pkg::CH0_REGION) || (addr[4:3] == pwt_pkg::CH1_REGION);
  assign ch_idx = (addr[4:3] == pwt_pkg::CH1_REGION);
  assign off    = addr[2:0];
  assign gr_idx = 2'(off - pwt_pkg::OFF_GR_A);
  assign ld_cnt[0] = wr_en && addr[4:3] == pwt_pkg::CH0_REGION && off == pwt_pkg::OFF_CNT;
  assign ld_cnt[1] = wr_en && addr[4:3] == pwt_pkg::CH1_REGION && off == pwt_pkg::OFF_CNT;

  // ****************************************
  // Count source
  // ****************************************
  assign ext_rise = q.ext_s[1] && !q.ext_s[2];
  assign ext_fall = !q.ext_s[1] && q.ext_s[2];
  assign hs_ok    = q.opt_s[5];

  always_comb begin
    if (q.edge_sel == pwt_pkg::EDGE_RISE) begin
      ext_edge = ext_rise;
    end else if (q.edge_sel == pwt_pkg::EDGE_FALL) begin
      ext_edge = ext_fall;
    end else begin
      ext_edge = ext_rise || ext_fall;
    end
    case (pwt_pkg::pwt_src_t'(q.src))
      pwt_pkg::SRC_DIV1:  src_tick = 1'b1;
      pwt_pkg::SRC_DIV2:  src_tick = q.presc[0];
      pwt_pkg::SRC_DIV4:  src_tick = &q.presc[1:0];
      pwt_pkg::SRC_DIV8:  src_tick = &q.presc[2:0];
      pwt_pkg::SRC_DIV32: src_tick = &q.presc;
      pwt_pkg::SRC_HSOSC: src_tick = hs_ok;
      pwt_pkg::SRC_EXT:   src_tick = q.extclk && ext_edge;
      default:            src_tick = 1'b0;
    endcase
  end

  // ****************************************
  // Registers and control
  // ****************************************
  always_comb begin
    d       = q;
    d.ext_s = {q.ext_s[1], q.ext_s[0], ch0_a_pin};
    d.cut_s = {q.cut_s[0], ext_irq0_pin};
    d.pen_s = {q.pen_s[0], timer_periph_enable};
    d.opt_s = {q.opt_s[2:0], osc_freq_select_bit, osc_freq_code};
    d.presc = q.presc + 5'h01;
    // Enable off stops counting; clock switch order is software's job
    d.tick     = src_tick && q.pen_s[1];
    d.cutoff   = q.cut_en && !q.cut_s[1];
    d.ihs_half = (q.opt_s[4:3] == pwt_pkg::OSC_64) || (q.opt_s[4:3] == pwt_pkg::OSC_48);
    for (int i = 0; i < 2; i++) begin
      d.irq[i] = |ch_match[i] || ch_ovf[i];
      if (ch_stop[i]) begin
        d.start[i] = 1'b0;
      end
    end
    d.adc = |({ch_match[1], ch_match[0]} & q.evmask);
    // Software write comes last so a start written with a stop wins
    if (wr_en) begin
      if (addr == pwt_pkg::ADDR_START) begin
        d.start    = wr_data[pwt_pkg::START_RUN_LSB +: 2];
        d.stop_sel = wr_data[pwt_pkg::START_SEL_LSB +: 2];
      end else if (addr == pwt_pkg::ADDR_CFG) begin
        d.src      = wr_data[pwt_pkg::CFG_SRC_LSB +: 3];
        d.edge_sel = wr_data[pwt_pkg::CFG_EDGE_LSB +: 2];
        d.cut_en   = wr_data[pwt_pkg::CFG_CUT_EN_BIT];
        d.extclk   = wr_data[pwt_pkg::CFG_EXTCLK_BIT];
      end else if (addr == pwt_pkg::ADDR_EVMASK) begin
        d.evmask = wr_data[7:0];
      end else if (ch_hit && off >= pwt_pkg::OFF_GR_A && off <= pwt_pkg::OFF_GR_D) begin
        d.gr[ch_idx][gr_idx] = wr_data;
      end else if (ch_hit && off == pwt_pkg::OFF_OUTCFG) begin
        d.outcfg[ch_idx] = wr_data[8:0];
      end
    end
    d.rdata = 16'h0000;
    if (rd_en) begin
      if (addr == pwt_pkg::ADDR_START) begin
        d.rdata[pwt_pkg::START_RUN_LSB +: 2] = q.start;
        d.rdata[pwt_pkg::START_SEL_LSB +: 2] = q.stop_sel;
      end else if (addr == pwt_pkg::ADDR_CFG) begin
        d.rdata[pwt_pkg::CFG_SRC_LSB +: 3]  = q.src;
        d.rdata[pwt_pkg::CFG_EDGE_LSB +: 2] = q.edge_sel;
        d.rdata[pwt_pkg::CFG_CUT_EN_BIT]    = q.cut_en;
        d.rdata[pwt_pkg::CFG_EXTCLK_BIT]    = q.extclk;
      end else if (addr == pwt_pkg::ADDR_EVMASK) begin
        d.rdata[7:0] = q.evmask;
      end else if (addr == pwt_pkg::ADDR_STATUS) begin
        d.rdata[pwt_pkg::STAT_RUN_LSB +: 2] = q.start;
        d.rdata[pwt_pkg::STAT_CUT_BIT]      = q.cutoff;
        d.rdata[pwt_pkg::STAT_HALF_BIT]     = q.ihs_half;
        d.rdata[pwt_pkg::STAT_HS_OK_BIT]    = hs_ok;
      end else if (ch_hit && off == pwt_pkg::OFF_CNT) begin
        d.rdata = ch_cnt[ch_idx];
      end else if (ch_hit && off >= pwt_pkg::OFF_GR_A && off <= pwt_pkg::OFF_GR_D) begin
        d.rdata = q.gr[ch_idx][gr_idx];
      end else if (ch_hit && off == pwt_pkg::OFF_OUTCFG) begin
        d.rdata[8:0] = q.outcfg[ch_idx];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q          <= '0;
      q.presc    <= pwt_pkg::RST_PRESC;
      q.evmask   <= pwt_pkg::RST_EVMASK;
      q.gr       <= {8{pwt_pkg::RST_GR}};
      q.outcfg   <= {2{pwt_pkg::RST_OUTCFG}};
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  for (genvar i = 0; i < 2; i++) begin : g_ch
    pwt_channel u_ch (
      .clk      (clk),
      .rst_n    (rst_n),
      .tick     (q.tick),
      .run      (q.start[i]),
      .stop_sel (q.stop_sel[i]),
      .ld_cnt   (ld_cnt[i]),
      .ld_val   (wr_data),
      .gr_a     (q.gr[i][0]),
      .gr_b     (q.gr[i][1]),
      .gr_c     (q.gr[i][2]),
      .gr_d     (q.gr[i][3]),
      .pin_en   (q.outcfg[i][pwt_pkg::OUT_EN_LSB +: 3]),
      .act_hi   (q.outcfg[i][pwt_pkg::OUT_ACT_LSB +: 3]),
      .init_lvl (q.outcfg[i][pwt_pkg::OUT_INIT_LSB +: 3]),
      .cutoff   (q.cutoff),
      .cnt      (ch_cnt[i]),
      .match    (ch_match[i]),
      .ovf      (ch_ovf[i]),
      .stop_req (ch_stop[i]),
      .pin_o    (ch_pin_o[i]),
      .pin_oe   (ch_pin_oe[i])
    );
    assign pwm_o[3*i +: 3]  = ch_pin_o[i];
    assign pwm_oe[3*i +: 3] = ch_pin_oe[i];
  end

  assign rd_data          = q.rdata;
  assign irq_req          = q.irq;
  assign adc_trig         = q.adc;
  assign internal_hs_half = q.ihs_half;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_cnt_read;
    rd_en && ch_hit && off == pwt_pkg::OFF_CNT;
  endsequence

  chk_count_read: assert property (s_cnt_read |=> rd_data == $past(ch_cnt[ch_idx]))
    else $error("counter read wrong");
  chk_start_write: assert property (
    wr_en && addr == pwt_pkg::ADDR_START && wr_data[0] |=> q.start[0])
    else $error("start bit not set");
  chk_hs_gate: assert property (q.src == pwt_pkg::SRC_HSOSC && !hs_ok |=> !q.tick)
    else $error("oscillator source ticked while not allowed");
  chk_full_rate: assert property (q.src == pwt_pkg::SRC_DIV1 && q.pen_s[1] |=> q.tick)
    else $error("undivided source missed a tick");
  chk_ext_edge: assert property (
    q.src == pwt_pkg::SRC_EXT && q.extclk && q.pen_s[1]
    && q.edge_sel == pwt_pkg::EDGE_RISE && ext_rise |=> q.tick)
    else $error("external edge not counted");
  chk_adc_event: assert property (|(ch_match[0] & q.evmask[3:0]) |=> adc_trig)
    else $error("event link pulse missing");
  chk_irq_ovf: assert property (ch_ovf[1] |=> irq_req[1])
    else $error("overflow request missing");
  chk_half_clock: assert property (q.opt_s[4:3] == pwt_pkg::OSC_64 |=> internal_hs_half)
    else $error("internal clock not halved");
  chk_cutoff_set: assert property (q.cut_en && !q.cut_s[1] |=> ##1 pwm_oe == 6'h00)
    else $error("cutoff did not release pins");
endmodule

//--- testbench/tb.sv
// Self-checking bench for the two-channel PWM timer
`timescale 1ns/10ps
module tb;
  logic        clk;
  logic        arst_n;
  logic [4:0]  addr;
  logic [15:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] rd_data;
  logic        ch0_a_pin;
  logic        ext_irq0_pin;
  logic        osc_freq_select_bit;
  logic [1:0]  osc_freq_code;
  logic        timer_periph_enable;
  logic [5:0]  pwm_o;
  logic [5:0]  pwm_oe;
  logic [1:0]  irq_req;
  logic        adc_trig;
  logic        internal_hs_half;
  int          error_cnt;
  int          cmp_count;
  int          cyc;
  int          n_hi;
  int          n_irq;
  int          n_trig;
  logic [15:0] rv;
  logic [15:0] rv2;
  logic [5:0]  held;

  pwt_top u_pwt_top (
    .clk                 (clk),
    .arst_n              (arst_n),
    .addr                (addr),
    .wr_data             (wr_data),
    .wr_en               (wr_en),
    .rd_en               (rd_en),
    .rd_data             (rd_data),
    .ch0_a_pin           (ch0_a_pin),
    .ext_irq0_pin        (ext_irq0_pin),
    .osc_freq_select_bit (osc_freq_select_bit),
    .osc_freq_code       (osc_freq_code),
    .timer_periph_enable (timer_periph_enable),
    .pwm_o               (pwm_o),
    .pwm_oe              (pwm_oe),
    .irq_req             (irq_req),
    .adc_trig            (adc_trig),
    .internal_hs_half    (internal_hs_half)
  );

  // ****************************************
  // Clock, timeout and verdict
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 870 cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      $display("ERROR %0t run did not finish", $time);
      close_out();
    end
  end

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_num(input int got, input int exp, input string what);
    cmp_count++;
    if (got != exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
  endtask

  task automatic measure(input int n, input int c);
    n_hi   = 0;
    n_irq  = 0;
    n_trig = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      n_hi   += (pwm_o[3*c] === 1'b1) ? 1 : 0;
      n_irq  += (irq_req[c] === 1'b1) ? 1 : 0;
      n_trig += (adc_trig === 1'b1) ? 1 : 0;
    end
  endtask

  // Stop channel 0, load compares and output setup, restart from zero
  task automatic restart(input logic [15:0] a, input logic [15:0] b, input logic [15:0] oc);
    wr(5'h00, 16'h0004);
    wr(5'h09, a);
    wr(5'h0A, b);
    wr(5'h0D, oc);
    wr(5'h08, 16'h0000);
    wr(5'h00, 16'h0005);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  logic [15:0] wave_tab [3][3];
  initial begin
    wave_tab = '{'{16'h0001, 16'h0009, 16'h0014}, '{16'h0000, 16'h0009, 16'h001E},
                 '{16'h0000, 16'h0001, 16'h000A}};
    arst_n = 1'b0;
    addr = 5'h00;
    wr_data = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ch0_a_pin = 1'b0;
    ext_irq0_pin = 1'b1;
    osc_freq_select_bit = 1'b0;
    osc_freq_code = 2'h0;
    timer_periph_enable = 1'b1;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(5'h09, rv);
    chk_val(rv, 16'hFFFF, "compare reset");
    rd(5'h0D, rv);
    chk_val(rv, 16'h0038, "outcfg reset");
    rd(5'h1F, rv);
    chk_val(rv, 16'h0000, "unmapped read");
    wr(5'h03, 16'hFFFF);
    rd(5'h03, rv);
    chk_val(rv, 16'h0000, "status read-only");
    wr(5'h08, 16'h1234);
    rd(5'h08, rv);
    chk_val(rv, 16'h1234, "counter load");
    wr(5'h02, 16'h0001);
    // Window of 40 cycles is ten whole periods of A=3
    for (int i = 0; i < 3; i++) begin
      restart(16'h0003, wave_tab[i][0], wave_tab[i][1]);
      repeat (8) @(posedge clk);
      measure(40, 0);
      chk_num(n_hi, int'(wave_tab[i][2]), "high cycles");
      chk_num(n_irq, 20, "match requests");
      chk_num(n_trig, 10, "conversion triggers");
    end
    rd(5'h08, rv);
    chk_num(int'(rv <= 16'h0003), 1, "live count in period");
    wr(5'h00, 16'h0004);
    @(posedge clk);
    #1;
    held = pwm_o;
    rd(5'h08, rv);
    repeat (10) @(posedge clk);
    rd(5'h08, rv2);
    chk_val(rv2, rv, "count held");
    chk_val({10'h000, pwm_o}, {10'h000, held}, "pins held");
    wr(5'h00, 16'h0001);
    repeat (20) @(posedge clk);
    rd(5'h08, rv);
    chk_val(rv, 16'h0003, "stop at period");
    rd(5'h03, rv);
    chk_val(rv & 16'h0001, 16'h0000, "start cleared");
    for (int i = 0; i < 2; i++) begin
      restart(16'h00FF, 16'h0080, i ? 16'h0049 : 16'h0009);
      repeat (5) @(posedge clk);
      chk_val({15'h0000, pwm_o[0]}, i ? 16'h0001 : 16'h0000, "initial level");
      chk_val({10'h000, pwm_oe}, 16'h0001, "pin enable");
    end
    wr(5'h01, 16'h0020);
    ext_irq0_pin <= 1'b0;
    repeat (8) @(posedge clk);
    chk_val({10'h000, pwm_oe}, 16'h0000, "cutoff drive");
    rd(5'h03, rv);
    chk_val(rv & 16'h0004, 16'h0004, "cutoff status");
    @(posedge clk);
    ext_irq0_pin <= 1'b1;
    // External pin clock: 5 pulses give 5 or 10 counted edges
    for (int e = 0; e < 3; e++) begin
      restart(16'hFFF0, 16'h0080, 16'h0009);
      wr(5'h01, 16'h0046 | (16'(e) << 3));
      wr(5'h08, 16'h0000);
      repeat (5) begin
        ch0_a_pin <= 1'b1;
        repeat (4) @(posedge clk);
        ch0_a_pin <= 1'b0;
        repeat (4) @(posedge clk);
      end
      repeat (6) @(posedge clk);
      rd(5'h08, rv);
      chk_val(rv, (e == 2) ? 16'h000A : 16'h0005, "external edges");
    end
    wr(5'h01, 16'h0005);
    wr(5'h08, 16'h0000);
    repeat (10) @(posedge clk);
    rd(5'h08, rv);
    chk_val(rv, 16'h0000, "oscillator locked out");
    @(posedge clk);
    osc_freq_select_bit <= 1'b1;
    osc_freq_code <= 2'h2;
    repeat (10) @(posedge clk);
    rd(5'h08, rv);
    chk_num(int'(rv != 16'h0000), 1, "oscillator counts");
    rd(5'h03, rv);
    chk_val(rv & 16'h0018, 16'h0018, "half and osc status");
    chk_val({15'h0000, internal_hs_half}, 16'h0001, "half at 64");
    @(posedge clk);
    osc_freq_code <= 2'h0;
    repeat (6) @(posedge clk);
    chk_val({15'h0000, internal_hs_half}, 16'h0000, "equal at 32");
    // Enable off freezes the count, as needed before any system clock change
    timer_periph_enable <= 1'b0;
    repeat (4) @(posedge clk);
    rd(5'h08, rv);
    repeat (10) @(posedge clk);
    rd(5'h08, rv2);
    chk_val(rv2, rv, "enable off holds count");
    @(posedge clk);
    timer_periph_enable <= 1'b1;
    // Two reads 64 cycles apart span whole prescaler wraps
    for (int s = 1; s < 5; s++) begin
      wr(5'h01, 16'(s));
      rd(5'h08, rv);
      repeat (62) @(posedge clk);
      rd(5'h08, rv2);
      chk_val(rv2 - rv, (s == 4) ? 16'h0002 : 16'h0040 >> s, "divided source");
    end
    // Channel 1 from just below wrap: overflow request, then periods of 4
    wr(5'h01, 16'h0000);
    wr(5'h02, 16'h0010);
    wr(5'h11, 16'h0003);
    wr(5'h15, 16'h0001);
    wr(5'h10, 16'hFFFD);
    wr(5'h00, 16'h000A);
    measure(40, 1);
    chk_num(n_hi, 33, "ch1 pin high cycles");
    chk_num(n_irq, 9, "ch1 match and overflow requests");
    chk_num(n_trig, 8, "ch1 conversion triggers");
    chk_val({13'h0000, pwm_oe[5:3]}, 16'h0001, "ch1 pin enable");
    close_out();
  end
endmodule
